/* File: hw/torque_consts.svh */
// Constants for the torque command path
`ifndef TORQUE_CONSTS_SVH
`define TORQUE_CONSTS_SVH
`define TQ_SRC_INTERNAL      1'h0
`define TQ_SRC_ANALOG        1'h1
`define LIM_SRC_INTERNAL     1'h0
`define LIM_SRC_EXTERNAL     1'h1
`define TQ_SETPOINT_MAX      16'sh0BB8
`define TQ_LIMIT_MAX         16'sh0BB8
`define ZERO_OFFSET_MAX      16'sh01F4
`define BIAS_MAX             16'sh1388
`define DEAD_ZONE_MAX        16'h03E8
`define DEAD_ZONE_RESET      16'h0014
`define AIN_TC_MAX           16'hEA60
`define AIN_TC_RESET         16'h00C8
`define TQ_TC_RESET          16'h0032
`define FWD_LIMIT_RESET      16'h0BB8
`define REV_LIMIT_RESET      16'h0BB8
`define DO_FUNC_TQ_LIMITED   8'h8B
// Filter time constant unit is 0.01 ms = 10000 ns; clock period 5 ns
`define TC_UNIT_NS           10000
`define CLK_PERIOD_NS        5
`define TC_UNIT_CYCLES       (`TC_UNIT_NS / `CLK_PERIOD_NS)
`define GAIN_FRAC_BITS       12
`endif

/* File: hw/torque_pkg.sv */
// Types shared by the torque command path
package torque_pkg;
	typedef logic signed [15:0] tq_val_t;
	typedef logic [15:0]        tc_val_t;
endpackage

/* File: hw/filter_if.sv */
// Carrier between the main path and a first-order filter
`timescale 1ns/1ps
interface filter_if;
	torque_pkg::tq_val_t x;
	torque_pkg::tq_val_t y;
	torque_pkg::tc_val_t tc;
	modport ctrl (output x, output tc, input y);
	modport filt (input x, input tc, output y);
endinterface

/* File: hw/lp_filter.sv */
// First-order low-pass filter, one update every time-constant unit
`timescale 1ns/1ps
`include "torque_consts.svh"
module lp_filter #(
	parameter int UNIT_CYC = `TC_UNIT_CYCLES
) (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_b,
	// Filter carrier
	filter_if.filt    f
);
	typedef struct packed {
		logic [15:0]        tick;
		logic signed [47:0] acc;  // y scaled by 2^16
	} st_t;
	st_t s_q;
	st_t s_d;
	logic signed [47:0] err;
	logic signed [47:0] step;
	// y += (x - y)/tc each unit; tc of 0 or 1 passes straight through
	always_comb begin
		s_d = s_q;
		err = ({{16{f.x[15]}}, f.x, 16'h0000}) - s_q.acc;
		step = (f.tc > 16'd1) ? err / $signed({32'h0, f.tc}) : err;
		if (s_q.tick == 16'(UNIT_CYC - 1)) begin
			s_d.tick = 16'h0000;
			s_d.acc = s_q.acc + step;
		end else begin
			s_d.tick = s_q.tick + 16'h0001;
		end
		if (f.tc <= 16'd1) begin
			s_d.acc = {{16{f.x[15]}}, f.x, 16'h0000};
		end
	end
	// State register; reset starts the output at zero
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign f.y = s_q.acc[31:16];
endmodule

/* File: hw/torque_command_path.sv */
// Torque command path: source select, analog conditioning, filter, limit
// ------------------------------------------------------------------
// Behaviour
// R1: Source select 0 internal, 1 analog
// R2: Reduced variant: internal source, no conditioning
// R3: Internal source uses clamped setpoint directly
// R4: Analog source converts conditioned channel A
// R5: Subtract zero-drift correction, clamp to 500
// R6: Apply bias after drift correction
// R7: Dead zone forces sample to zero
// R8: Channel A first-order low-pass filter
// R9: Torque command first-order low-pass filter
// R10: Clamp magnitude to active limit
// R11: One active limit, never beyond 300 percent
// R12: Limit source 0 internal, 1 external
// R13: Internal forward and reverse limit parameters
// R14: External limit from channel B torque
// R15: Limited flag on output with code 139
// R16: Linear voltage-to-torque with gain
// ------------------------------------------------------------------
`timescale 1ns/1ps
`include "torque_consts.svh"
module torque_command_path #(
	parameter bit FULL_VARIANT = 1'b1,
	parameter int UNIT_CYC     = `TC_UNIT_CYCLES
) (
	// Clock and reset
	input  wire logic                i_ref_clk,
	input  wire logic                i_rst_b,
	// Configuration
	input  wire logic                i_torque_source_select,
	input  wire torque_pkg::tq_val_t i_internal_torque_setpoint,
	input  wire torque_pkg::tq_val_t i_analog_a_bias,
	input  wire torque_pkg::tc_val_t i_analog_a_filter_tc,
	input  wire torque_pkg::tc_val_t i_analog_a_dead_zone,
	input  wire torque_pkg::tq_val_t i_analog_a_zero_offset,
	input  wire torque_pkg::tc_val_t i_torque_filter_tc,
	input  wire logic                i_limit_source_select,
	input  wire torque_pkg::tq_val_t i_forward_torque_limit,
	input  wire torque_pkg::tq_val_t i_reverse_torque_limit,
	input  wire torque_pkg::tq_val_t i_analog_gain,
	input  wire logic [7:0]          i_do_function,
	input  wire logic                i_do_active_low,
	// Sampled analog channels in mV (from converter, other domain)
	input  wire torque_pkg::tq_val_t i_analog_channel_a,
	input  wire torque_pkg::tq_val_t i_analog_channel_b,
	// Results
	output torque_pkg::tq_val_t      o_torque_cmd,
	output logic                     o_torque_limited,
	output logic                     o_digital_out
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] a_s1;
		logic [15:0] a_s2;
		logic [15:0] b_s1;
		logic [15:0] a_s3;
		logic [15:0] a_v;     // Last channel A word seen steady
		logic [15:0] b_s2;
		logic [15:0] b_s3;
		logic [15:0] b_v;     // Last channel B word seen steady
		logic [15:0] cond_a;
		logic [15:0] raw_cmd;
		logic [15:0] cmd;
		logic        limited;
		logic        dout;
	} st_t;
	st_t s_q;
	st_t s_d;

	filter_if ain_f();
	filter_if tq_f();

	logic signed [15:0] zoff;
	logic signed [15:0] bias;
	logic signed [17:0] corr;
	logic signed [17:0] dz;
	logic signed [17:0] cond;
	logic signed [33:0] prod;
	logic signed [15:0] tq_a;
	logic signed [15:0] tq_b;
	logic signed [15:0] sp;
	logic signed [15:0] fwd;
	logic signed [15:0] rev;
	logic signed [15:0] filt_cmd;
	logic               use_analog;
	logic               ext_limit;

	// Saturate to +/- the given magnitude
	function automatic logic signed [15:0] sat(
		input logic signed [33:0] v,
		input logic signed [15:0] m
	);
		if (v > 34'(m)) begin
			return m;
		end else if (v < -34'(m)) begin
			return -m;
		end
		return v[15:0];
	endfunction

	// Reduced variant hides the analog source and conditioning
	assign use_analog = FULL_VARIANT
		&& (i_torque_source_select == `TQ_SRC_ANALOG); // R1 R2
	assign ext_limit = FULL_VARIANT
		&& (i_limit_source_select == `LIM_SRC_EXTERNAL); // R12 R2

	// ------------------------------------------------------------------
	// Analog channel A conditioning
	// ------------------------------------------------------------------
	// Drift removed first so bias is referenced to a true zero input
	always_comb begin
		zoff = sat(34'(i_analog_a_zero_offset), `ZERO_OFFSET_MAX); // R5
		bias = sat(34'(i_analog_a_bias), `BIAS_MAX); // R6
		corr = 18'($signed(s_q.a_v)) - 18'(zoff); // R5
		corr = corr - 18'(bias); // R6
		dz = 18'($signed({1'b0, (i_analog_a_dead_zone > `DEAD_ZONE_MAX)
			? `DEAD_ZONE_MAX : i_analog_a_dead_zone}));
		// Dead band is symmetric; outside it the slope stays continuous
		if (corr > dz) begin
			cond = corr - dz; // R7
		end else if (corr < -dz) begin
			cond = corr + dz;
		end else begin
			cond = 18'sd0;
		end
	end

	// Channel A filter, time constant clamped to its range
	assign ain_f.x  = FULL_VARIANT ? s_q.cond_a : 16'h0000; // R8
	assign ain_f.tc = (i_analog_a_filter_tc > `AIN_TC_MAX)
		? `AIN_TC_MAX : i_analog_a_filter_tc;
	lp_filter #(.UNIT_CYC(UNIT_CYC)) u_ain_filt (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.f         (ain_f)
	);

	// ------------------------------------------------------------------
	// Conversion, source selection and limits
	// ------------------------------------------------------------------
	// mV times gain (Q12) gives 0.1 percent units; linear map
	always_comb begin
		prod = 34'($signed(ain_f.y)) * 34'(i_analog_gain);
		tq_a = sat(prod >>> `GAIN_FRAC_BITS, `TQ_SETPOINT_MAX); // R16 R4
		prod = 34'($signed(s_q.b_v)) * 34'(i_analog_gain);
		tq_b = sat(prod >>> `GAIN_FRAC_BITS, `TQ_LIMIT_MAX); // R14
		if (tq_b < 16'sd0) begin
			tq_b = -tq_b; // R14
		end
		sp = sat(34'(i_internal_torque_setpoint), `TQ_SETPOINT_MAX); // R3
		// Only one limit pair is in force; both capped at 300 percent
		if (ext_limit) begin
			fwd = tq_b; // R11 R14
			rev = tq_b;
		end else begin
			fwd = sat(34'(i_forward_torque_limit), `TQ_LIMIT_MAX); // R13
			rev = sat(34'(i_reverse_torque_limit), `TQ_LIMIT_MAX); // R11
			if (fwd < 16'sd0) fwd = 16'sd0;
			if (rev < 16'sd0) rev = 16'sd0;
		end
	end

	// Command filter before the limiter so the clamp is exact
	assign tq_f.x  = s_q.raw_cmd; // R9
	assign tq_f.tc = i_torque_filter_tc;
	assign filt_cmd = tq_f.y;
	lp_filter #(.UNIT_CYC(UNIT_CYC)) u_tq_filt (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.f         (tq_f)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// Two flops on converter words from the other domain
		s_d.a_s1 = i_analog_channel_a;
		s_d.a_s2 = s_q.a_s1;
		s_d.a_s3 = s_q.a_s2;
		s_d.b_s1 = i_analog_channel_b;
		s_d.b_s2 = s_q.b_s1;
		s_d.b_s3 = s_q.b_s2;
		// A word may be caught mid-change; it is taken only once two
		// successive samples agree, at the cost of one more edge
		if (s_q.a_s2 == s_q.a_s3) begin
			s_d.a_v = s_q.a_s2; // R4
		end
		if (s_q.b_s2 == s_q.b_s3) begin
			s_d.b_v = s_q.b_s2; // R14
		end
		s_d.cond_a = sat(34'(cond), 16'sh7FFF);
		s_d.raw_cmd = use_analog ? tq_a : sp; // R1 R3 R4
		if (filt_cmd > fwd) begin
			s_d.cmd = fwd; // R10
			s_d.limited = 1'b1; // R15
		end else if (filt_cmd < -rev) begin
			s_d.cmd = -rev; // R10
			s_d.limited = 1'b1;
		end else begin
			s_d.cmd = filt_cmd; // R10
			s_d.limited = 1'b0;
		end
		// Output only when the terminal carries the limit function
		s_d.dout = ((i_do_function == `DO_FUNC_TQ_LIMITED)
			&& s_d.limited) ^ i_do_active_low; // R15
	end

	// All state in one register; reset clears every stage
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_torque_cmd     = s_q.cmd;
	assign o_torque_limited = s_q.limited;
	assign o_digital_out    = s_q.dout;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_cmd_in_limit;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		$signed(o_torque_cmd) <= `TQ_LIMIT_MAX
			&& $signed(o_torque_cmd) >= -`TQ_LIMIT_MAX;
	endproperty
	a_cmd_in_limit: assert property (p_cmd_in_limit) // R11
		else $error("command beyond 300 percent");

	property p_clamp_fwd;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(filt_cmd > fwd)
			|=> (o_torque_cmd == $past(fwd)) && o_torque_limited;
	endproperty
	a_clamp_fwd: assert property (p_clamp_fwd) // R10
		else $error("forward clamp wrong");

	property p_pass;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(filt_cmd <= fwd && filt_cmd >= -rev)
			|=> (o_torque_cmd == $past(filt_cmd)) && !o_torque_limited;
	endproperty
	a_pass: assert property (p_pass) // R10
		else $error("unlimited command altered");

	property p_internal_src;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(!use_analog) |=> (s_q.raw_cmd == $past(sp));
	endproperty
	a_internal_src: assert property (p_internal_src) // R3
		else $error("internal setpoint not selected");

	property p_dead_zone;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(corr <= dz && corr >= -dz) |=> (s_q.cond_a == 16'h0000);
	endproperty
	a_dead_zone: assert property (p_dead_zone) // R7
		else $error("dead zone not applied");

	property p_dout;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_do_function != `DO_FUNC_TQ_LIMITED)
			|=> (o_digital_out == $past(i_do_active_low));
	endproperty
	a_dout: assert property (p_dout) // R15
		else $error("output driven without code 139");

	property p_ext_sym;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		ext_limit |-> (fwd == rev) && (fwd >= 16'sd0);
	endproperty
	a_ext_sym: assert property (p_ext_sym) // R14
		else $error("external limit not symmetric");

	property p_src_default;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		!FULL_VARIANT |-> !use_analog && !ext_limit
			&& (ain_f.y == 16'sh0000);
	endproperty
	a_src_default: assert property (p_src_default) // R2
		else $error("reduced variant uses analog");

	property p_clamp_rev;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(filt_cmd < -rev)
			|=> (o_torque_cmd == -$past(rev)) && o_torque_limited;
	endproperty
	a_clamp_rev: assert property (p_clamp_rev) // R10
		else $error("reverse clamp wrong");

	property p_analog_src;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		use_analog |=> ($signed(s_q.raw_cmd) == $past(tq_a));
	endproperty
	a_analog_src: assert property (p_analog_src) // R4
		else $error("analog command not selected");

	property p_dout_flag;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_do_function == `DO_FUNC_TQ_LIMITED)
			|=> (o_digital_out == (o_torque_limited ^ $past(i_do_active_low)));
	endproperty
	a_dout_flag: assert property (p_dout_flag) // R15
		else $error("limited flag missing from its output");

	c_limited: cover property (@(posedge i_ref_clk) o_torque_limited);
	c_analog:  cover property (@(posedge i_ref_clk) use_analog);
	c_ext:     cover property (@(posedge i_ref_clk) ext_limit
		&& o_torque_limited);
	c_dout:    cover property (@(posedge i_ref_clk) o_digital_out
		&& o_torque_limited);
endmodule

/* File: sim/host_model.sv */
// Host controller model: analog channel words and output assignment
`timescale 1ns/1ps
module host_model (
	// Analog channel words in mV
	output torque_pkg::tq_val_t o_channel_a,
	output torque_pkg::tq_val_t o_channel_b,
	// Digital output assignment
	output logic [7:0]          o_do_function,
	output logic                o_do_active_low
);
	// ----------------------------------------
	// Levels
	// ----------------------------------------
	// Held like a converter output: a new level only on request
	initial begin
		o_channel_a = 16'h0000;
		o_channel_b = 16'h0000;
		o_do_function = 8'h8B;
		o_do_active_low = 1'b0;
	end

	// Caller changes levels just after a falling edge
	task automatic apply(input int a, input int b, input logic [7:0] fn,
		input logic al);
		o_channel_a = 16'(a);
		o_channel_b = 16'(b);
		o_do_function = fn;
		o_do_active_low = al;
	endtask
endmodule

/* File: sim/tb.sv */
// Self-checking bench of the torque command path
`timescale 1ns/1ps
module tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                i_ref_clk;
	logic                i_rst_b;
	logic                i_torque_source_select;
	logic                i_limit_source_select;
	torque_pkg::tq_val_t i_internal_torque_setpoint;
	torque_pkg::tq_val_t i_analog_a_bias;
	torque_pkg::tq_val_t i_analog_a_zero_offset;
	torque_pkg::tq_val_t i_forward_torque_limit;
	torque_pkg::tq_val_t i_reverse_torque_limit;
	torque_pkg::tq_val_t i_analog_gain;
	torque_pkg::tq_val_t i_analog_channel_a;
	torque_pkg::tq_val_t i_analog_channel_b;
	torque_pkg::tc_val_t i_analog_a_filter_tc;
	torque_pkg::tc_val_t i_analog_a_dead_zone;
	torque_pkg::tc_val_t i_torque_filter_tc;
	logic [7:0]          i_do_function;
	logic                i_do_active_low;
	torque_pkg::tq_val_t cmd [2];
	logic                lim [2];
	logic                dout [2];
	int                  bad_count;
	int                  checked;
	int                  seed;

	host_model i_host_model (.o_channel_a(i_analog_channel_a),
		.o_channel_b(i_analog_channel_b), .o_do_function(i_do_function),
		.o_do_active_low(i_do_active_low));

	// Full variant at index 0, reduced variant at index 1
	for (genvar g = 0; g < 2; g++) begin : g_var
		torque_command_path #(.FULL_VARIANT(g == 0), .UNIT_CYC(2))
			i_torque_command_path (.i_ref_clk, .i_rst_b,
			.i_torque_source_select, .i_internal_torque_setpoint,
			.i_analog_a_bias, .i_analog_a_filter_tc, .i_analog_a_dead_zone,
			.i_analog_a_zero_offset, .i_torque_filter_tc,
			.i_limit_source_select, .i_forward_torque_limit,
			.i_reverse_torque_limit, .i_analog_gain, .i_do_function,
			.i_do_active_low, .i_analog_channel_a, .i_analog_channel_b,
			.o_torque_cmd(cmd[g]), .o_torque_limited(lim[g]),
			.o_digital_out(dout[g]));
	end

	// ----------------------------------------
	// Helpers and reference model
	// ----------------------------------------
	function automatic int rnd(int m);
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return (seed & 32'h7FFF_FFFF) % m;
	endfunction

	function automatic int sat(int v, int m);
		return v > m ? m : (v < -m ? -m : v);
	endfunction

	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %0d seen %0d", n,
				$signed(exp), $signed(seen));
		end
	endtask

	// Reduced variant ignores both selects
	task automatic check_all();
		int t, d, z, lf, lr;
		logic l;
		for (int v = 0; v < 2; v++) begin
			l = 1'b0;
			if (i_torque_source_select && v == 0) begin
				d = i_analog_channel_a - sat(i_analog_a_zero_offset, 500);
				d = d - sat(i_analog_a_bias, 5000);
				z = i_analog_a_dead_zone > 1000 ? 1000 : i_analog_a_dead_zone;
				d = d > z ? d - z : (d < -z ? d + z : 0);
				t = sat(d * i_analog_gain / 4096, 3000);
			end else
				t = sat(i_internal_torque_setpoint, 3000);
			lf = i_forward_torque_limit;
			lr = i_reverse_torque_limit;
			if (i_limit_source_select && v == 0) begin
				lf = i_analog_channel_b * i_analog_gain / 4096;
				lf = lf < 0 ? -lf : lf;
				lf = lf > 3000 ? 3000 : lf;
				lr = lf;
			end
			if (t > lf) begin
				t = lf;
				l = 1'b1;
			end
			if (t < -lr) begin
				t = -lr;
				l = 1'b1;
			end
			chk("torque_cmd", cmd[v],
				16'(t));
			chk("limited", 16'(lim[v]), 16'(l));
			chk("do_level", 16'(dout[v]), 16'((l & (i_do_function == 8'h8B))
				^ i_do_active_low));
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end

	// Tests need about 3500 cycles; a hang is cut well beyond that
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		bad_count++;
		end_of_test();
	end

	initial begin
		seed = 74;
		i_rst_b = 1'b0;
		{i_torque_source_select, i_limit_source_select} = 2'h0;
		i_internal_torque_setpoint = 16'h0000;
		i_analog_a_bias = 16'h0000;
		i_analog_a_zero_offset = 16'h0000;
		i_forward_torque_limit = 16'h0BB8;
		i_reverse_torque_limit = 16'h0BB8;
		i_analog_gain = 16'h1000;
		i_analog_a_filter_tc = 16'h00C8;
		i_analog_a_dead_zone = 16'h0014;
		i_torque_filter_tc = 16'h0032;
		repeat (6) @(negedge i_ref_clk);
		chk("reset_cmd", cmd[0], 16'h0000);
		repeat (6) @(negedge i_ref_clk);
		i_rst_b = 1'b1;
		repeat (20) @(negedge i_ref_clk);
		check_all();
		$display("test reset_defaults done");
		// Step through the command filter, then the channel filter
		for (int f = 0; f < 2; f++) begin
			i_torque_filter_tc = f ? 16'h0000 : 16'h0008;
			i_analog_a_filter_tc = f ? 16'h0008 : 16'h0000;
			i_analog_a_dead_zone = 16'h0000;
			i_torque_source_select = f[0];
			i_host_model.apply(0, 0, 8'h8B, 1'b0);
			i_internal_torque_setpoint = 16'h0000;
			repeat (400) @(negedge i_ref_clk);
			i_host_model.apply(2000, 0, 8'h8B, 1'b0);
			i_internal_torque_setpoint = 16'h07D0;
			repeat (12) @(negedge i_ref_clk);
			chk("filter_mid", 16'(cmd[0] > 0 && cmd[0] < 2000),
				16'h0001);
			repeat (400) @(negedge i_ref_clk);
			chk("filter_end", 16'(cmd[0] > 1992), 16'h0001);
		end
		$display("test filters done");
		i_analog_a_filter_tc = 16'h0000;
		// Random settings, including values beyond the legal ranges
		for (int n = 0; n < 150; n++) begin
			i_torque_source_select = 1'(rnd(2));
			i_limit_source_select = 1'(rnd(2));
			i_internal_torque_setpoint = 16'(rnd(7001) - 3500);
			i_analog_a_bias = 16'(rnd(11001) - 5500);
			i_analog_a_zero_offset = 16'(rnd(1201) - 600);
			i_analog_a_dead_zone = 16'(rnd(1200));
			i_forward_torque_limit = 16'(rnd(3001));
			i_reverse_torque_limit = 16'(rnd(3001));
			i_analog_gain = rnd(2) ? 16'h1000 : 16'h2000;
			i_host_model.apply(rnd(8001) - 4000, rnd(4001) - 2000,
				rnd(2) ? 8'h8B : 8'h8A, 1'(rnd(2)));
			repeat (12) @(negedge i_ref_clk);
			check_all();
		end
		$display("test random_settings done");
		end_of_test();
	end
endmodule
